/* tb/nibble_sub_xor_datapath_tb.sv */
// self-checking bench for the nibble subtract / xor datapath
// assumes memory reads are combinational, so the bench itself plays the memory read port
`timescale 1ns/1ps
`default_nettype none
module nibble_sub_xor_datapath_tb;
  import nibble_alu_pkg::*;
  typedef struct {
    logic [3:0] accum;
    logic       c;
    logic       z;
    logic       we;
  } note_s;
  logic                  i_clock;
  logic                  i_rst;
  alu_op_e               i_op;
  logic [MEM_ADDR_W-1:0] i_mem_addr;
  logic [3:0]            i_mem_rdata;
  logic [WREG_SEL_W-1:0] i_wreg_sel;
  logic [3:0]            i_immediate;
  logic [MEM_ADDR_W-1:0] o_mem_addr;
  logic                  o_mem_we;
  logic [3:0]            o_mem_wdata;
  logic [3:0]            o_accumulator;
  logic                  o_carry_flag;
  logic                  o_zero_flag;
  logic [3:0]            o_wreg_data;
  note_s                 q[$];
  logic [3:0]            m_accum;
  logic                  m_c;
  logic                  m_z;
  logic [6:0]            m_addr;
  logic [3:0]            m_wd;
  logic [3:0]            m_wreg[WREG_COUNT];
  logic [31:0]           seed;
  int                    error_cnt;
  int                    total_checks;

  nibble_sub_xor_datapath i_nibble_sub_xor_datapath (
    .i_clock(i_clock), .i_rst(i_rst), .i_op(i_op), .i_mem_addr(i_mem_addr),
    .i_mem_rdata(i_mem_rdata), .i_wreg_sel(i_wreg_sel), .i_immediate(i_immediate),
    .o_mem_addr(o_mem_addr), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
    .o_accumulator(o_accumulator), .o_carry_flag(o_carry_flag),
    .o_zero_flag(o_zero_flag), .o_wreg_data(o_wreg_data));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk_val(input string nm, input logic [6:0] e, input logic [6:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic model_reset();
    m_accum = ACCUM_RESET;
    m_c = FLAG_RESET;
    m_z = FLAG_RESET;
    m_addr = 7'h00;
    m_wd = NIBBLE_ZERO;
    foreach (m_wreg[k]) m_wreg[k] = NIBBLE_ZERO;
  endtask

  // entered at a rising edge; the op is taken at the next edge and the model follows it there
  task automatic do_op(input alu_op_e op);
    note_s      n;
    logic       mem;
    logic       sub;
    logic [3:0] a;
    logic [3:0] b;
    logic [4:0] d;
    seed = xs(seed);
    #1;
    i_op = op;
    i_mem_addr = seed[6:0];
    i_mem_rdata = seed[10:7];
    i_wreg_sel = seed[14:11];
    i_immediate = seed[18:15];
    @(posedge i_clock);
    mem = (op == OP_SUB_STORE_MEM) || (op == OP_XOR_ACCUM_MEM) || (op == OP_XOR_STORE_MEM);
    sub = (op == OP_SUB_STORE_MEM) || (op == OP_SUB_STORE_WREG);
    a = mem ? i_mem_rdata : m_wreg[i_wreg_sel];
    b = mem ? m_accum : i_immediate;
    d = {1'b0, a} - {1'b0, b};
    if (op != OP_NONE) begin
      m_accum = sub ? d[3:0] : (a ^ b);
      m_z = (m_accum == NIBBLE_ZERO);
      if (sub) m_c = ~d[4];
    end
    n.we = (op == OP_SUB_STORE_MEM) || (op == OP_XOR_STORE_MEM);
    if (n.we) begin
      m_addr = i_mem_addr;
      m_wd = m_accum;
    end
    if ((op == OP_SUB_STORE_WREG) || (op == OP_XOR_STORE_WREG)) m_wreg[i_wreg_sel] = m_accum;
    n.accum = m_accum;
    n.c = m_c;
    n.z = m_z;
    q.push_back(n);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if ((error_cnt == 0) && (total_checks > 0)) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin : monitor
    note_s n;
    forever begin
      @(posedge i_clock);
      #2;
      if (q.size() > 0) begin
        n = q.pop_front();
        chk_val("accumulator", {3'h0, n.accum}, {3'h0, o_accumulator});
        chk_bit("carry_flag", n.c, o_carry_flag);
        chk_bit("zero_flag", n.z, o_zero_flag);
        chk_bit("mem_we", n.we, o_mem_we);
        chk_val("mem_addr", m_addr, o_mem_addr);
        chk_val("mem_wdata", {3'h0, m_wd}, {3'h0, o_mem_wdata});
        chk_val("wreg", {3'h0, m_wreg[i_wreg_sel]}, {3'h0, o_wreg_data});
      end
    end
  end

  initial begin
    seed = 32'h0000_002A;
    error_cnt = 0;
    total_checks = 0;
    i_rst = 1'b1;
    i_op = OP_NONE;
    i_mem_addr = 7'h00;
    i_mem_rdata = 4'h0;
    i_wreg_sel = 4'h0;
    i_immediate = 4'h0;
    model_reset();
    repeat (3) @(posedge i_clock);
    #1 i_rst = 1'b0;
    @(posedge i_clock);
    do_op(OP_NONE);
    // walk every op back to back, then a long random mix
    repeat (3) for (int k = 0; k < 7; k++) do_op(alu_op_e'(k));
    for (int k = 0; k < 400; k++) do_op(alu_op_e'(3'(xs(seed) % 32'd7)));
    // reset in mid-run must clear accumulator, flags and working registers;
    // go idle first so no stale op is taken again once reset lets go
    do_op(OP_NONE);
    @(posedge i_clock);
    #1 i_rst = 1'b1;
    model_reset();
    @(posedge i_clock);
    #1 i_rst = 1'b0;
    @(posedge i_clock);
    do_op(OP_NONE);
    for (int k = 0; k < 40; k++) do_op(alu_op_e'(3'(xs(seed) % 32'd7)));
    for (int k = 0; (k < 5) && (q.size() > 0); k++) @(posedge i_clock);
    if (q.size() > 0) error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire

/* verilog/nibble_alu_core.sv */
// combinational nibble arithmetic: subtract with carry and exclusive-or
// assumes operands are already selected by the caller
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_core
  import nibble_alu_pkg::*;
(
  input  wire logic [3:0] i_minuend,
  input  wire logic [3:0] i_subtrahend,
  input  wire logic       i_do_xor,
  output logic      [3:0] o_result,
  output logic            o_carry,
  output logic            o_zero
);
  logic [4:0] diff;

  always_comb begin
    // carry is 1 when no borrow occurs, the usual 4-bit core convention
    diff = {1'b0, i_minuend} + {1'b0, ~i_subtrahend} + 5'h01;
    if (i_do_xor) begin
      o_result = i_minuend ^ i_subtrahend;
    end else begin
      o_result = diff[3:0];
    end
    o_carry = diff[4];                    // RQ7
    o_zero  = (o_result == NIBBLE_ZERO);  // RQ7
  end
endmodule
`default_nettype wire

/* verilog/nibble_alu_pkg.sv */
// constants and operation codes for the nibble subtract / xor datapath
// assumes a decoder upstream that turns instruction words into an operation select
`default_nettype none
package nibble_alu_pkg;
  localparam int  NIBBLE_W     = 4;
  localparam int  MEM_ADDR_W   = 7;
  localparam int  WREG_SEL_W   = 4;
  localparam int  WREG_COUNT   = 16;
  localparam logic [3:0] ACCUM_RESET = 4'h0;
  localparam logic       FLAG_RESET = 1'b0;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  // every operation completes in one machine cycle
  localparam int  OP_CYCLES    = 1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SUB_STORE_MEM,
    OP_SUB_STORE_WREG,
    OP_XOR_ACCUM_MEM,
    OP_XOR_ACCUM_WREG,
    OP_XOR_STORE_MEM,
    OP_XOR_STORE_WREG
  } alu_op_e;
endpackage
`default_nettype wire

/* verilog/nibble_sub_xor_datapath.sv */
// execution datapath for subtract-store-back and exclusive-or instructions
// assumes data memory is external with a one-cycle write strobe;
// working registers are held here as flip-flops
//
// Summary of operation
// RQ1: memory subtract: accumulator and memory take memory minus accumulator, both flags
// RQ2: register subtract: accumulator and register take register minus immediate, both flags
// RQ3: memory xor: accumulator takes memory xor accumulator, only zero flag changes
// RQ4: register xor: accumulator takes register xor immediate, only zero flag changes
// RQ5: memory xor store back: memory and accumulator take result, zero flag only
// RQ6: register xor store back: register and accumulator take result, zero flag only
// RQ7: zero flag set on all-zero result; carry is the subtract carry out
`timescale 1ns/1ps
`default_nettype none
module nibble_sub_xor_datapath
  import nibble_alu_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire alu_op_e               i_op,
  input  wire logic [MEM_ADDR_W-1:0] i_mem_addr,
  input  wire logic [3:0]            i_mem_rdata,
  input  wire logic [WREG_SEL_W-1:0] i_wreg_sel,
  input  wire logic [3:0]            i_immediate,
  output logic      [MEM_ADDR_W-1:0] o_mem_addr,
  output logic                       o_mem_we,
  output logic      [3:0]            o_mem_wdata,
  output logic      [3:0]            o_accumulator,
  output logic                       o_carry_flag,
  output logic                       o_zero_flag,
  output logic      [3:0]            o_wreg_data
);
  logic [3:0] accum_ff, nxt_accum;
  logic       carry_ff, nxt_carry;
  logic       zero_ff, nxt_zero;
  logic [3:0] wreg_ff [WREG_COUNT];
  logic [3:0] nxt_wreg [WREG_COUNT];
  logic       mem_we_ff, nxt_mem_we;
  logic [3:0] mem_wdata_ff, nxt_mem_wdata;
  logic [MEM_ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;

  logic [3:0] opa, opb, res;
  logic       do_xor, res_carry, res_zero;

  function automatic logic op_uses_wreg(input alu_op_e op);
    return op == OP_SUB_STORE_WREG || op == OP_XOR_ACCUM_WREG || op == OP_XOR_STORE_WREG;
  endfunction

  always_comb begin
    opa    = op_uses_wreg(i_op) ? wreg_ff[i_wreg_sel] : i_mem_rdata;
    opb    = op_uses_wreg(i_op) ? i_immediate : accum_ff;
    do_xor = !(i_op == OP_SUB_STORE_MEM || i_op == OP_SUB_STORE_WREG);
  end

  nibble_alu_core i_nibble_alu_core (
    .i_minuend    (opa),
    .i_subtrahend (opb),
    .i_do_xor     (do_xor),
    .o_result     (res),
    .o_carry      (res_carry),
    .o_zero       (res_zero)
  );

  always_comb begin
    nxt_accum     = accum_ff;
    nxt_carry     = carry_ff;
    nxt_zero      = zero_ff;
    nxt_wreg      = wreg_ff;
    nxt_mem_we    = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_mem_addr  = mem_addr_ff;
    case (i_op)
      OP_SUB_STORE_MEM: begin
        nxt_accum     = res;        // RQ1
        nxt_carry     = res_carry;  // RQ1
        nxt_zero      = res_zero;   // RQ1
        nxt_mem_we    = 1'b1;       // RQ1
        nxt_mem_wdata = res;
        nxt_mem_addr  = i_mem_addr;
      end
      OP_SUB_STORE_WREG: begin
        nxt_accum            = res;        // RQ2
        nxt_carry            = res_carry;  // RQ2
        nxt_zero             = res_zero;   // RQ2
        nxt_wreg[i_wreg_sel] = res;        // RQ2
      end
      OP_XOR_ACCUM_MEM: begin
        nxt_accum = res;       // RQ3
        nxt_zero  = res_zero;  // RQ3
      end
      OP_XOR_ACCUM_WREG: begin
        nxt_accum = res;       // RQ4
        nxt_zero = res_zero;  // RQ4
      end
      OP_XOR_STORE_MEM: begin
        nxt_accum     = res;       // RQ5
        nxt_zero      = res_zero;  // RQ5
        nxt_mem_we    = 1'b1;      // RQ5
        nxt_mem_wdata = res;
        nxt_mem_addr  = i_mem_addr;
      end
      OP_XOR_STORE_WREG: begin
        nxt_accum            = res;       // RQ6
        nxt_zero             = res_zero;  // RQ6
        nxt_wreg[i_wreg_sel] = res;       // RQ6
      end
      default: begin
        nxt_mem_we = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      accum_ff     <= ACCUM_RESET;
      carry_ff     <= FLAG_RESET;
      zero_ff      <= FLAG_RESET;
      mem_we_ff    <= 1'b0;
      mem_wdata_ff <= NIBBLE_ZERO;
      mem_addr_ff  <= '0;
    end else begin
      accum_ff     <= nxt_accum;
      carry_ff     <= nxt_carry;
      zero_ff      <= nxt_zero;
      mem_we_ff    <= nxt_mem_we;
      mem_wdata_ff <= nxt_mem_wdata;
      mem_addr_ff  <= nxt_mem_addr;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WREG_COUNT; g++) begin : gen_wreg
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          wreg_ff[g] <= NIBBLE_ZERO;
        end else begin
          wreg_ff[g] <= nxt_wreg[g];
        end
      end
    end
  endgenerate

  always_comb begin
    o_accumulator = accum_ff;
    o_carry_flag  = carry_ff;
    o_zero_flag   = zero_ff;
    o_mem_we      = mem_we_ff;
    o_mem_wdata   = mem_wdata_ff;
    o_mem_addr    = mem_addr_ff;
    o_wreg_data   = wreg_ff[i_wreg_sel];
  end

  // checks
  sequence s_mem_sub;
    i_op == OP_SUB_STORE_MEM;
  endsequence

  sequence s_mem_store;
    i_op == OP_SUB_STORE_MEM || i_op == OP_XOR_STORE_MEM;
  endsequence

  sequence s_no_mem_store;
    !(i_op == OP_SUB_STORE_MEM || i_op == OP_XOR_STORE_MEM);
  endsequence

  sequence s_no_wreg_store;
    !(i_op == OP_SUB_STORE_WREG || i_op == OP_XOR_STORE_WREG);
  endsequence

  AST_SUB_MEM: assert property (@(posedge i_clock) disable iff (i_rst) // RQ1
    s_mem_sub |=> o_mem_we && o_accumulator == ($past(i_mem_rdata) - $past(o_accumulator))
                  && o_mem_wdata == o_accumulator && o_mem_addr == $past(i_mem_addr))
    else $error("memory subtract result wrong");

  AST_SUB_WREG: assert property (@(posedge i_clock) disable iff (i_rst) // RQ2
    i_op == OP_SUB_STORE_WREG |=> o_accumulator == ($past(o_wreg_data) - $past(i_immediate))
        && wreg_ff[$past(i_wreg_sel)] == o_accumulator && !o_mem_we)
    else $error("register subtract result wrong");

  AST_XOR_ACCUM_MEM: assert property (@(posedge i_clock) disable iff (i_rst) // RQ3
    i_op == OP_XOR_ACCUM_MEM |=> o_accumulator == ($past(i_mem_rdata) ^ $past(o_accumulator))
        && !o_mem_we && $stable(o_carry_flag))
    else $error("memory xor result wrong");

  AST_XOR_ACCUM_WREG: assert property (@(posedge i_clock) disable iff (i_rst) // RQ4
    i_op == OP_XOR_ACCUM_WREG |=> o_accumulator == ($past(o_wreg_data) ^ $past(i_immediate))
        && $stable(o_carry_flag) && !o_mem_we)
    else $error("register xor result wrong");

  AST_XOR_STORE_MEM: assert property (@(posedge i_clock) disable iff (i_rst) // RQ5
    i_op == OP_XOR_STORE_MEM |=> o_mem_we && o_mem_wdata == o_accumulator
        && o_accumulator == ($past(i_mem_rdata) ^ $past(o_accumulator)) && $stable(o_carry_flag))
    else $error("memory xor store back wrong");

  AST_XOR_STORE_WREG: assert property (@(posedge i_clock) disable iff (i_rst) // RQ6
    i_op == OP_XOR_STORE_WREG |=> wreg_ff[$past(i_wreg_sel)] == o_accumulator
        && $stable(o_carry_flag) && !o_mem_we)
    else $error("register xor store back wrong");

  AST_ZERO: assert property (@(posedge i_clock) disable iff (i_rst) // RQ7
    i_op != OP_NONE |=> o_zero_flag == (o_accumulator == NIBBLE_ZERO))
    else $error("zero flag mismatch");

  AST_CARRY: assert property (@(posedge i_clock) disable iff (i_rst) // RQ7
    (i_op == OP_SUB_STORE_MEM || i_op == OP_SUB_STORE_WREG)
      |=> o_carry_flag == ($past(opa) >= $past(opb)))
    else $error("carry flag mismatch");

  AST_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
    i_op == OP_NONE |=> $stable(o_accumulator) && !o_mem_we)
    else $error("idle changed state");

  AST_WE_QUIET: assert property (@(posedge i_clock) disable iff (i_rst) // RQ3
    s_no_mem_store |=> !o_mem_we)
    else $error("memory strobe without a store back");

  AST_STORE_ADDR: assert property (@(posedge i_clock) disable iff (i_rst) // RQ5
    s_mem_store |=> o_mem_addr == $past(i_mem_addr) && o_mem_wdata == o_accumulator)
    else $error("store back address or data wrong");

  AST_STORE_HOLD: assert property (@(posedge i_clock) disable iff (i_rst) // RQ1
    s_no_mem_store |=> $stable(o_mem_addr) && $stable(o_mem_wdata))
    else $error("store back address or data moved");

  AST_WREG_KEEP: assert property (@(posedge i_clock) disable iff (i_rst) // RQ4
    s_no_wreg_store |=> wreg_ff[$past(i_wreg_sel)] == $past(o_wreg_data))
    else $error("working register changed without a store back");
endmodule
`default_nettype wire
